//--- ictc_map.svh
// Register indices, field positions, reset values and masks of the IDE timing bank
`ifndef ICTC_MAP_SVH
`define ICTC_MAP_SVH

`define ICTC_IDX_BAR 8'h10
`define ICTC_IDX_BOARD_ID 8'h2c
`define ICTC_IDX_MISC 8'h53
`define ICTC_IDX_PRI_FIFO 8'h54
`define ICTC_IDX_SEC_FIFO 8'h55
`define ICTC_IDX_PRI_FDMA 8'h56
`define ICTC_IDX_SEC_FDMA 8'h57
`define ICTC_IDX_PRI_ASU 8'h58
`define ICTC_IDX_PRI_CMD 8'h59
`define ICTC_IDX_PRI_D0 8'h5a
`define ICTC_IDX_PRI_D1 8'h5b
`define ICTC_IDX_SEC_ASU 8'h5c
`define ICTC_IDX_SEC_CMD 8'h5d
`define ICTC_IDX_SEC_D0 8'h5e
`define ICTC_IDX_SEC_D1 8'h5f
`define ICTC_IDX_DESC_BYTES 8'h60
`define ICTC_IDX_BLK_CNT 8'h67
`define ICTC_IDX_SEC_BSIZE 8'h6a
`define ICTC_IDX_PRI_SECCNT 8'h6c
`define ICTC_IDX_SEC_SECCNT 8'h6d
`define ICTC_IDX_PRI_CMDCPY 8'h6e
`define ICTC_IDX_SEC_CMDCPY 8'h6f
`define ICTC_IDX_PRI_BCLO 8'h70
`define ICTC_IDX_PRI_BCHI 8'h71
`define ICTC_IDX_SEC_BCLO 8'h72
`define ICTC_IDX_SEC_BCHI 8'h73
`define ICTC_IDX_FIFO_STATE 8'h74
`define ICTC_IDX_CLK_FREQ 8'h78

`define ICTC_RST_FIFO_CFG 8'h55
`define ICTC_RST_ZERO8 8'h00
`define ICTC_RST_BLK_CNT 8'h01
`define ICTC_RST_CLK_FREQ 8'h21

`define ICTC_MASK_MISC 8'h8b
`define ICTC_MASK_ASU 8'h07
`define ICTC_MASK_TIMING 8'h7f
`define ICTC_MASK_BAR 32'hfffff000

`define ICTC_MISC_ID_LOCK 7
`define ICTC_MISC_BAR_MASK 3
`define ICTC_MISC_BUF_OFF 1
`define ICTC_MISC_CD_DMA 0

`define ICTC_THRESH_BASE 5'h0c
`define ICTC_LEN3_ZERO 5'h08
`define ICTC_LEN4_ZERO 5'h10

`endif

//--- ictc_pkg.sv
// Types and decode helpers shared by the IDE timing bank
`include "ictc_map.svh"

package ictc_pkg;

  typedef enum logic [1:0] {
    ICTC_PIO_DIRECT = 2'h0,
    ICTC_PIO_FIFO = 2'h1,
    ICTC_DMA_FIFO = 2'h2,
    ICTC_MODE_RSVD = 2'h3
  } ictc_mode_t;

  typedef struct packed {
    ictc_mode_t mode;
    logic [4:0] thresh_words;
    logic udma_en;
    logic [4:0] udma_half_clks;
  } ictc_drive_cfg_t;

  typedef struct packed {
    logic start;
    logic is_data;
    logic drive;
  } ictc_acc_req_t;

  typedef struct packed {
    logic busy;
    logic addr_setup;
    logic strobe;
    logic recover;
    logic done;
  } ictc_phase_t;

  typedef struct packed {
    logic wr;
    logic chan;
    logic [1:0] sel;
    logic [7:0] data;
  } ictc_tf_write_t;

  // Code zero is the longest length
  function automatic logic [4:0] ictc_len3(input logic [2:0] code);
    ictc_len3 = (code == 3'h0) ? `ICTC_LEN3_ZERO : {2'h0, code};
  endfunction

  function automatic logic [4:0] ictc_len4(input logic [3:0] code);
    ictc_len4 = (code == 4'h0) ? `ICTC_LEN4_ZERO : {1'h0, code};
  endfunction

  // Half clock periods, so 1.5T is whole
  function automatic logic [4:0] ictc_udma_half(input logic [2:0] code);
    unique case (code)
      3'h0: ictc_udma_half = 5'h10;
      3'h1: ictc_udma_half = 5'h03;
      3'h2: ictc_udma_half = 5'h04;
      3'h3: ictc_udma_half = 5'h06;
      3'h4: ictc_udma_half = 5'h08;
      3'h5: ictc_udma_half = 5'h05;
      3'h6: ictc_udma_half = 5'h0c;
      3'h7: ictc_udma_half = 5'h07;
    endcase
  endfunction

endpackage

//--- ictc_strobe_timer.sv
// Per-channel strobe sequencer: setup, active, recovery
`timescale 1ns/10ps
`default_nettype none

module ictc_strobe_timer
  import ictc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Access request and timing fields
  input wire ictc_acc_req_t req,
  input wire logic [7:0] setup_reg,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] data0_reg,
  input wire logic [7:0] data1_reg,
  // Phase outputs
  output ictc_phase_t phase
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_ACTIVE = 4'b0100,
    ST_RECOVER = 4'b1000
  } ictc_tstate_t;

  ictc_tstate_t state_reg;
  logic [4:0] cnt_reg;
  logic [4:0] act_len_reg;
  logic [4:0] rec_len_reg;
  logic done_reg;
  logic [7:0] data_sel;

  assign data_sel = req.drive ? data1_reg : data0_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      act_len_reg <= 5'h08;
      rec_len_reg <= 5'h10;
    end else if (state_reg == ST_IDLE && req.start) begin
      act_len_reg <= ictc_len3(req.is_data ? data_sel[6:4] : cmd_reg[6:4]);
      rec_len_reg <= ictc_len4(req.is_data ? data_sel[3:0] : cmd_reg[3:0]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (req.start) begin
            cnt_reg <= ictc_len3(setup_reg[2:0]) - 5'h01;
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_reg == 5'h00) begin
            cnt_reg <= act_len_reg - 5'h01;
            state_reg <= ST_ACTIVE;
          end else begin
            cnt_reg <= cnt_reg - 5'h01;
          end
        end
        ST_ACTIVE: begin
          if (cnt_reg == 5'h00) begin
            cnt_reg <= rec_len_reg - 5'h01;
            state_reg <= ST_RECOVER;
          end else begin
            cnt_reg <= cnt_reg - 5'h01;
          end
        end
        ST_RECOVER: begin
          if (cnt_reg == 5'h00) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == ST_RECOVER) && (cnt_reg == 5'h00);
    end
  end

  assign phase.busy = (state_reg != ST_IDLE);
  assign phase.addr_setup = (state_reg == ST_SETUP);
  assign phase.strobe = (state_reg == ST_ACTIVE);
  assign phase.recover = (state_reg == ST_RECOVER);
  assign phase.done = done_reg;

endmodule

`default_nettype wire

//--- ictc_top.sv
// IDE channel timing and shadow register bank with APB slave
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "ictc_map.svh"

// How it works
// - Misc bit7 locks board maker identifier
// - Bit3 masks base address in compatibility
// - Bit1 set turns data buffer off
// - Bit0 enables optical drive DMA
// - Two-bit field selects drive operation mode
// - Threshold field gives twelve to fifteen words
// - FIFO config registers reset to 55h
// - Per-drive fast DMA enable bit
// - Three-bit code selects fast DMA cycle
// - Secondary channel has own fast DMA
// - Address setup count, zero means eight
// - Command active count, zero means eight
// - Command recovery count, zero means sixteen
// - Per-drive data active count, zero eight
// - Per-drive data recovery, zero sixteen
// - Read-only descriptor byte counter, reset zero
// - Read-only block size counter, reset 01h
// - Read-only secondary device0 block size
// - Mirror primary task-file writes read-only
// - Mirror secondary task-file writes read-only
// - IDE clock frequency register, default 33
module ictc_top
  import ictc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller state to shadow
  input wire logic compat_mode,
  input wire logic [15:0] desc_bytes_in,
  input wire logic [7:0] block_count_in,
  input wire logic [7:0] sec_dev0_bsize_in,
  input wire logic [7:0] fifo_state_in,
  input wire ictc_tf_write_t tf_write,
  // Channel access requests
  input wire ictc_acc_req_t pri_req,
  input wire ictc_acc_req_t sec_req,
  // Configuration to the drive engine
  output ictc_drive_cfg_t [3:0] drive_cfg,
  output logic buffer_off,
  output logic cdrom_dma_en,
  output logic [7:0] ide_clk_mhz,
  // Strobe phases per channel
  output ictc_phase_t pri_phase,
  output ictc_phase_t sec_phase
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [7:0] idx;
  logic wr_en;
  logic wr_b0;
  logic setup_ph;

  assign idx = paddr[9:2];
  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign wr_b0 = wr_en && pstrb[0];
  // No wait state: read data is taken in setup
  assign pready = psel && penable;

  function automatic logic [31:0] ictc_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    ictc_merge = res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Software-written registers

  logic [7:0] misc_reg;
  logic [15:0] board_id_reg;
  logic [31:0] bar_reg;
  logic [7:0] pri_fifo_reg;
  logic [7:0] sec_fifo_reg;
  logic [7:0] pri_fdma_reg;
  logic [7:0] sec_fdma_reg;
  logic [7:0] pri_asu_reg;
  logic [7:0] pri_cmd_reg;
  logic [7:0] pri_d0_reg;
  logic [7:0] pri_d1_reg;
  logic [7:0] sec_asu_reg;
  logic [7:0] sec_cmd_reg;
  logic [7:0] sec_d0_reg;
  logic [7:0] sec_d1_reg;
  logic [7:0] clk_freq_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      misc_reg <= `ICTC_RST_ZERO8;
    end else if (wr_b0 && idx == `ICTC_IDX_MISC) begin
      misc_reg <= pwdata[7:0] & `ICTC_MASK_MISC;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      board_id_reg <= 16'h0000;
    end else if (wr_en && idx == `ICTC_IDX_BOARD_ID && !misc_reg[`ICTC_MISC_ID_LOCK]) begin
      board_id_reg <= ictc_merge(32'(board_id_reg), pwdata, pstrb)
        [15:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bar_reg <= 32'h00000000;
    end else if (wr_en && idx == `ICTC_IDX_BAR) begin
      bar_reg <= ictc_merge(bar_reg, pwdata, pstrb) & `ICTC_MASK_BAR;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pri_fifo_reg <= `ICTC_RST_FIFO_CFG;
      sec_fifo_reg <= `ICTC_RST_FIFO_CFG;
    end else if (wr_b0) begin
      if (idx == `ICTC_IDX_PRI_FIFO) begin
        pri_fifo_reg <= pwdata[7:0];
      end
      if (idx == `ICTC_IDX_SEC_FIFO) begin
        sec_fifo_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pri_fdma_reg <= `ICTC_RST_ZERO8;
      sec_fdma_reg <= `ICTC_RST_ZERO8;
    end else if (wr_b0) begin
      if (idx == `ICTC_IDX_PRI_FDMA) begin
        pri_fdma_reg <= pwdata[7:0];
      end
      if (idx == `ICTC_IDX_SEC_FDMA) begin
        sec_fdma_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pri_asu_reg <= `ICTC_RST_ZERO8;
      pri_cmd_reg <= `ICTC_RST_ZERO8;
      pri_d0_reg <= `ICTC_RST_ZERO8;
      pri_d1_reg <= `ICTC_RST_ZERO8;
      sec_asu_reg <= `ICTC_RST_ZERO8;
      sec_cmd_reg <= `ICTC_RST_ZERO8;
      sec_d0_reg <= `ICTC_RST_ZERO8;
      sec_d1_reg <= `ICTC_RST_ZERO8;
    end else if (wr_b0) begin
      unique case (idx)
        `ICTC_IDX_PRI_ASU: pri_asu_reg <= pwdata[7:0] & `ICTC_MASK_ASU;
        `ICTC_IDX_PRI_CMD: pri_cmd_reg <= pwdata[7:0] & `ICTC_MASK_TIMING;
        `ICTC_IDX_PRI_D0: pri_d0_reg <= pwdata[7:0] & `ICTC_MASK_TIMING;
        `ICTC_IDX_PRI_D1: pri_d1_reg <= pwdata[7:0] & `ICTC_MASK_TIMING;
        `ICTC_IDX_SEC_ASU: sec_asu_reg <= pwdata[7:0] & `ICTC_MASK_ASU;
        `ICTC_IDX_SEC_CMD: sec_cmd_reg <= pwdata[7:0] & `ICTC_MASK_TIMING;
        `ICTC_IDX_SEC_D0: sec_d0_reg <= pwdata[7:0] & `ICTC_MASK_TIMING;
        `ICTC_IDX_SEC_D1: sec_d1_reg <= pwdata[7:0] & `ICTC_MASK_TIMING;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      clk_freq_reg <= `ICTC_RST_CLK_FREQ;
    end else if (wr_b0 && idx == `ICTC_IDX_CLK_FREQ) begin
      clk_freq_reg <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadows of controller state

  logic [15:0] desc_bytes_reg;
  logic [7:0] block_cnt_reg;
  logic [7:0] sec_bsize_reg;
  logic [7:0] fifo_state_reg;
  logic [7:0] tf_copy_reg [2][4];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      desc_bytes_reg <= 16'h0000;
      block_cnt_reg <= `ICTC_RST_BLK_CNT;
      sec_bsize_reg <= `ICTC_RST_ZERO8;
      fifo_state_reg <= `ICTC_RST_ZERO8;
    end else begin
      desc_bytes_reg <= desc_bytes_in;
      block_cnt_reg <= block_count_in;
      sec_bsize_reg <= sec_dev0_bsize_in;
      fifo_state_reg <= fifo_state_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int c = 0; c < 2; c++) begin
        for (int s = 0; s < 4; s++) begin
          tf_copy_reg[c][s] <= `ICTC_RST_ZERO8;
        end
      end
    end else if (tf_write.wr) begin
      tf_copy_reg[tf_write.chan][tf_write.sel] <= tf_write.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [31:0] rd_data;
  logic rd_hit;

  always_comb begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    unique case (idx)
      `ICTC_IDX_BAR: rd_data = (misc_reg[`ICTC_MISC_BAR_MASK] && compat_mode) ?
        32'h00000000 : bar_reg;
      `ICTC_IDX_BOARD_ID: rd_data = 32'(board_id_reg);
      `ICTC_IDX_MISC: rd_data = 32'(misc_reg);
      `ICTC_IDX_PRI_FIFO: rd_data = 32'(pri_fifo_reg);
      `ICTC_IDX_SEC_FIFO: rd_data = 32'(sec_fifo_reg);
      `ICTC_IDX_PRI_FDMA: rd_data = 32'(pri_fdma_reg);
      `ICTC_IDX_SEC_FDMA: rd_data = 32'(sec_fdma_reg);
      `ICTC_IDX_PRI_ASU: rd_data = 32'(pri_asu_reg);
      `ICTC_IDX_PRI_CMD: rd_data = 32'(pri_cmd_reg);
      `ICTC_IDX_PRI_D0: rd_data = 32'(pri_d0_reg);
      `ICTC_IDX_PRI_D1: rd_data = 32'(pri_d1_reg);
      `ICTC_IDX_SEC_ASU: rd_data = 32'(sec_asu_reg);
      `ICTC_IDX_SEC_CMD: rd_data = 32'(sec_cmd_reg);
      `ICTC_IDX_SEC_D0: rd_data = 32'(sec_d0_reg);
      `ICTC_IDX_SEC_D1: rd_data = 32'(sec_d1_reg);
      `ICTC_IDX_DESC_BYTES: rd_data = 32'(desc_bytes_reg);
      `ICTC_IDX_BLK_CNT: rd_data = 32'(block_cnt_reg);
      `ICTC_IDX_SEC_BSIZE: rd_data = 32'(sec_bsize_reg);
      `ICTC_IDX_PRI_SECCNT: rd_data = 32'(tf_copy_reg[0][0]);
      `ICTC_IDX_SEC_SECCNT: rd_data = 32'(tf_copy_reg[1][0]);
      `ICTC_IDX_PRI_CMDCPY: rd_data = 32'(tf_copy_reg[0][1]);
      `ICTC_IDX_SEC_CMDCPY: rd_data = 32'(tf_copy_reg[1][1]);
      `ICTC_IDX_PRI_BCLO: rd_data = 32'(tf_copy_reg[0][2]);
      `ICTC_IDX_PRI_BCHI: rd_data = 32'(tf_copy_reg[0][3]);
      `ICTC_IDX_SEC_BCLO: rd_data = 32'(tf_copy_reg[1][2]);
      `ICTC_IDX_SEC_BCHI: rd_data = 32'(tf_copy_reg[1][3]);
      `ICTC_IDX_FIFO_STATE: rd_data = 32'(fifo_state_reg);
      `ICTC_IDX_CLK_FREQ: rd_data = 32'(clk_freq_reg);
      default: rd_hit = 1'b0;
    endcase
    if (paddr[11:10] != 2'h0) begin
      rd_hit = 1'b0;
      rd_data = 32'h00000000;
    end
  end

  // Unmapped addresses answer with an error and zero data
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= pwrite ? 32'h00000000 : rd_data;
      pslverr <= !rd_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded configuration

  logic [7:0] fifo_sel [4];
  logic [7:0] fdma_sel [4];

  always_comb begin
    for (int d = 0; d < 4; d++) begin
      fifo_sel[d] = (d < 2) ? pri_fifo_reg : sec_fifo_reg;
      fdma_sel[d] = (d < 2) ? pri_fdma_reg : sec_fdma_reg;
    end
  end

  always_comb begin
    for (int d = 0; d < 4; d++) begin
      // drive 1 high nibble, drive 0 low
      drive_cfg[d].mode = ictc_mode_t'(fifo_sel[d][(d % 2) * 4 + 2 +: 2]);
      drive_cfg[d].thresh_words = `ICTC_THRESH_BASE +
        {3'h0, fifo_sel[d][(d % 2) * 4 +: 2]};
      drive_cfg[d].udma_en = fdma_sel[d][(d % 2) * 4 + 3];
      drive_cfg[d].udma_half_clks = ictc_udma_half(fdma_sel[d][(d % 2) * 4 +: 3]);
    end
  end

  assign buffer_off = misc_reg[`ICTC_MISC_BUF_OFF];
  assign cdrom_dma_en = misc_reg[`ICTC_MISC_CD_DMA];
  assign ide_clk_mhz = clk_freq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe sequencers

  ictc_strobe_timer u_pri_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .req(pri_req),
    .setup_reg(pri_asu_reg),
    .cmd_reg(pri_cmd_reg),
    .data0_reg(pri_d0_reg),
    .data1_reg(pri_d1_reg),
    .phase(pri_phase)
  );

  ictc_strobe_timer u_sec_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .req(sec_req),
    .setup_reg(sec_asu_reg),
    .cmd_reg(sec_cmd_reg),
    .data0_reg(sec_d0_reg),
    .data1_reg(sec_d1_reg),
    .phase(sec_phase)
  );

endmodule

`default_nettype wire

//--- ictc_top_asserts.sv
// Concurrent checks on the ports of the IDE timing register bank
`timescale 1ns/10ps
`default_nettype none
`include "ictc_map.svh"

module ictc_top_asserts
  import ictc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // Primary request, configuration and phases
  input wire ictc_acc_req_t pri_req,
  input wire ictc_drive_cfg_t [3:0] drive_cfg,
  input wire logic buffer_off,
  input wire logic cdrom_dma_en,
  input wire logic [7:0] ide_clk_mhz,
  input wire ictc_phase_t pri_phase
);
  logic wr_now;
  assign wr_now = psel && penable && pwrite && pstrb[0] && (paddr[11:10] == 2'h0);

  default clocking cb @(posedge sys_clk);
  endclocking

  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr(logic [7:0] idx);
    wr_now && (paddr[9:2] == idx);
  endsequence
  sequence s_start;
    !pri_phase.busy && pri_req.start;
  endsequence
  sequence s_done_pulse;
    pri_phase.done ##1 !pri_phase.done;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // No disable: reset itself must give these
  AST_RESET_DFLT: assert property (reset |=> drive_cfg[3].mode == ICTC_PIO_FIFO
    && drive_cfg[3].thresh_words == 5'h0d && ide_clk_mhz == 8'h21)
    else $error("defaults wrong after reset");
  AST_FIFO_CFG: assert property (disable iff (reset) s_wr(8'h54) |=>
    drive_cfg[1].mode == $past(pwdata[7:6])
    && drive_cfg[0].thresh_words == 5'h0c + {3'h0, $past(pwdata[1:0])})
    else $error("fifo config not applied");
  AST_UDMA_EN: assert property (disable iff (reset) s_wr(8'h56) |=>
    drive_cfg[1].udma_en == $past(pwdata[7]) && drive_cfg[0].udma_en == $past(pwdata[3]))
    else $error("fast dma enable wrong");
  AST_UDMA_8T: assert property (disable iff (reset)
    s_wr(8'h56) && pwdata[2:0] == 3'h0 |=> drive_cfg[0].udma_half_clks == 5'h10)
    else $error("fast dma cycle code zero wrong");
  AST_SEC_UDMA: assert property (disable iff (reset) s_wr(8'h57) |=>
    drive_cfg[3].udma_en == $past(pwdata[7]) && $stable(drive_cfg[1]))
    else $error("secondary fast dma wrong");
  AST_MISC_BITS: assert property (disable iff (reset) s_wr(`ICTC_IDX_MISC) |=>
    buffer_off == $past(pwdata[1]) && cdrom_dma_en == $past(pwdata[0]))
    else $error("misc control bits wrong");
  AST_CLK_FREQ: assert property (disable iff (reset) s_wr(`ICTC_IDX_CLK_FREQ) |=>
    ide_clk_mhz == $past(pwdata[7:0]))
    else $error("clock frequency not written");
  AST_SETUP_FIRST: assert property (disable iff (reset) s_start |=>
    pri_phase.busy && pri_phase.addr_setup)
    else $error("setup not first");
  AST_STROBE_NEXT: assert property (disable iff (reset)
    $fell(pri_phase.addr_setup) && pri_phase.busy |-> pri_phase.strobe)
    else $error("strobe does not follow setup");
  AST_RECOVER_NEXT: assert property (disable iff (reset)
    $fell(pri_phase.strobe) |-> pri_phase.recover && pri_phase.busy)
    else $error("recovery does not follow strobe");
  AST_DONE: assert property (disable iff (reset) $fell(pri_phase.busy) |-> s_done_pulse)
    else $error("done pulse missing");
endmodule

bind ictc_top ictc_top_asserts chk_u (.*);
`default_nettype wire

//--- ictc_drive_model.sv
// Drive-side model: requests accesses and times each strobe phase
`timescale 1ns/10ps
`default_nettype none

module ictc_drive_model
  import ictc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Bench control and results
  input wire logic go,
  input wire logic is_data,
  input wire logic drive,
  output logic finished,
  output logic [4:0] n_setup,
  output logic [4:0] n_strobe,
  output logic [4:0] n_recover,
  // Timer side
  input wire ictc_phase_t phase,
  output ictc_acc_req_t req
);
  // Start held until busy, so a slow timer still sees it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      req <= '0;
    end else if (go) begin
      req <= '{start: 1'b1, is_data: is_data, drive: drive};
    end else if (phase.busy) begin
      req.start <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || go) begin
      n_setup <= '0;
      n_strobe <= '0;
      n_recover <= '0;
      finished <= 1'b0;
    end else begin
      n_setup <= n_setup + 5'(phase.addr_setup);
      n_strobe <= n_strobe + 5'(phase.strobe);
      n_recover <= n_recover + 5'(phase.recover);
      finished <= finished | phase.done;
    end
  end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the IDE timing register bank
`timescale 1ns/10ps
`default_nettype none
`include "ictc_map.svh"

module testbench
  import ictc_pkg::*;
();
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, compat_mode = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, buffer_off, cdrom_dma_en;
  logic [15:0] desc_bytes_in = '0;
  logic [7:0] block_count_in = 8'h01, sec_dev0_bsize_in = '0, fifo_state_in = '0;
  logic [7:0] ide_clk_mhz;
  ictc_tf_write_t tf_write = '0;
  ictc_acc_req_t pri_req, sec_req;
  ictc_drive_cfg_t [3:0] drive_cfg;
  ictc_phase_t pri_phase, sec_phase;
  logic [1:0] go = '0, is_data = '0, drive = '0, fin;
  logic [4:0] ns [2], nstb [2], nrec [2];
  logic [31:0] q;
  logic e;
  int n_errors = 0, comparisons = 0;

  always #50 sys_clk = ~sys_clk;

  ictc_top dut_u (.pstrb(4'hf), .*);
  ictc_drive_model pri_u (.sys_clk, .reset, .go(go[0]), .is_data(is_data[0]),
    .drive(drive[0]), .finished(fin[0]), .n_setup(ns[0]), .n_strobe(nstb[0]),
    .n_recover(nrec[0]), .phase(pri_phase), .req(pri_req));
  ictc_drive_model sec_u (.sys_clk, .reset, .go(go[1]), .is_data(is_data[1]),
    .drive(drive[1]), .finished(fin[1]), .n_setup(ns[1]), .n_strobe(nstb[1]),
    .n_recover(nrec[1]), .phase(sec_phase), .req(sec_req));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Starts after an edge; ends with one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, {2'h0, i, 2'h0}, d, q, e);
  endtask

  task automatic rd(input logic [7:0] i, input logic [31:0] exp);
    apb(1'b0, {2'h0, i, 2'h0}, '0, q, e);
    check($sformatf("reg %h", i), q, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    rd(`ICTC_IDX_PRI_FIFO, 32'h55);
    rd(`ICTC_IDX_SEC_FIFO, 32'h55);
    for (int i = 8'h56; i <= 8'h5f; i++) rd(8'(i), 32'h0);
    rd(`ICTC_IDX_CLK_FREQ, 32'h21);
    rd(`ICTC_IDX_BLK_CNT, 32'h01);
    check("cfg0", 32'(drive_cfg[0]), 32'({2'h1, 5'h0d, 1'b0, 5'h10}));
  endtask

  task automatic t_fifo;
    for (int k = 0; k < 4; k++) begin
      wr(`ICTC_IDX_PRI_FIFO, 32'({4{2'(k)}}));
      wr(`ICTC_IDX_SEC_FIFO, 32'({2'(k + 1), 2'(k + 2), 2'(k + 3), 2'(k)}));
      check("cfg0", 32'(drive_cfg[0][12:6]), 32'({2'(k), 5'(12 + k)}));
      check("cfg1", 32'(drive_cfg[1][12:6]), 32'({2'(k), 5'(12 + k)}));
      check("cfg2", 32'(drive_cfg[2][12:6]), 32'({2'(k + 3), 5'(12 + k)}));
      check("cfg3", 32'(drive_cfg[3][12:6]), 32'({2'(k + 1), 5'(12 + (k + 2) % 4)}));
      rd(`ICTC_IDX_PRI_FIFO, 32'({4{2'(k)}}));
    end
  endtask

  task automatic t_udma;
    logic [4:0] half [8] = '{5'h10, 5'h03, 5'h04, 5'h06, 5'h08, 5'h05, 5'h0c, 5'h07};
    for (int c = 0; c < 8; c++) begin
      wr(`ICTC_IDX_PRI_FDMA, 32'({1'b1, 3'(c), 1'b0, 3'(7 - c)}));
      wr(`ICTC_IDX_SEC_FDMA, 32'({1'b0, 3'(7 - c), 1'b1, 3'(c)}));
      check("udma1", 32'(drive_cfg[1][5:0]), 32'({1'b1, half[c]}));
      check("udma0", 32'(drive_cfg[0][5:0]), 32'({1'b0, half[7 - c]}));
      check("udma3", 32'(drive_cfg[3][5:0]), 32'({1'b0, half[7 - c]}));
      check("udma2", 32'(drive_cfg[2][5:0]), 32'({1'b1, half[c]}));
    end
    rd(`ICTC_IDX_SEC_FDMA, 32'h0f);
  endtask

  task automatic t_misc;
    wr(`ICTC_IDX_MISC, 32'hff);
    rd(`ICTC_IDX_MISC, 32'h8b);
    check("buf", 32'(buffer_off), 32'h1);
    check("cd", 32'(cdrom_dma_en), 32'h1);
    wr(`ICTC_IDX_BOARD_ID, 32'h1234);
    rd(`ICTC_IDX_BOARD_ID, 32'h0);
    wr(`ICTC_IDX_BAR, 32'hffffffff);
    compat_mode <= 1'b1;
    rd(`ICTC_IDX_BAR, 32'h0);
    wr(`ICTC_IDX_MISC, 32'h0);
    check("buf", 32'(buffer_off), 32'h0);
    check("cd", 32'(cdrom_dma_en), 32'h0);
    rd(`ICTC_IDX_BAR, 32'hfffff000);
    wr(`ICTC_IDX_BOARD_ID, 32'h1234);
    rd(`ICTC_IDX_BOARD_ID, 32'h1234);
    wr(`ICTC_IDX_MISC, 32'h08);
    compat_mode <= 1'b0;
    rd(`ICTC_IDX_BAR, 32'hfffff000);
    wr(`ICTC_IDX_CLK_FREQ, 32'h42);
    check("freq", 32'(ide_clk_mhz), 32'h42);
  endtask

  task automatic t_shadow;
    logic [7:0] mi [8] = '{8'h6c, 8'h6e, 8'h70, 8'h71, 8'h6d, 8'h6f, 8'h72, 8'h73};
    desc_bytes_in <= 16'hbeef;
    block_count_in <= 8'h5a;
    sec_dev0_bsize_in <= 8'hc3;
    fifo_state_in <= 8'h3c;
    for (int i = 0; i < 8; i++) begin
      tf_write <= {1'b1, 1'(i >> 2), 2'(i), 8'(8'ha0 + i)};
      @(posedge sys_clk);
    end
    tf_write <= '0;
    wr(mi[0], 32'hff);
    for (int i = 0; i < 8; i++) rd(mi[i], 32'(8'ha0 + i));
    rd(`ICTC_IDX_DESC_BYTES, 32'hbeef);
    rd(`ICTC_IDX_BLK_CNT, 32'h5a);
    rd(`ICTC_IDX_SEC_BSIZE, 32'hc3);
    rd(`ICTC_IDX_FIFO_STATE, 32'h3c);
    apb(1'b1, 12'hd50, 32'h0, q, e);
    check("unmapped err", 32'(e), 32'h1);
    apb(1'b0, 12'h184, 32'h0, q, e);
    check("gap data", q, 32'h0);
    check("gap err", 32'(e), 32'h1);
  endtask

  // Poke rewrites secondary command timing mid-access
  task automatic run_acc(input int ch, input logic dat, drv, poke, input int s, a, r);
    int n;
    is_data[ch] <= dat;
    drive[ch] <= drv;
    go[ch] <= 1'b1;
    @(posedge sys_clk);
    go[ch] <= 1'b0;
    // Let the model clear its old finished flag first
    @(posedge sys_clk);
    if (poke) wr(`ICTC_IDX_SEC_CMD, 32'h11);
    n = 0;
    while (fin[ch] !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    check("setup", 32'(ns[ch]), 32'(s));
    check("active", 32'(nstb[ch]), 32'(a));
    check("recover", 32'(nrec[ch]), 32'(r));
  endtask

  task automatic t_strobe;
    wr(`ICTC_IDX_PRI_ASU, 32'hfa);
    rd(`ICTC_IDX_PRI_ASU, 32'h02);
    wr(`ICTC_IDX_PRI_CMD, 32'hb1);
    rd(`ICTC_IDX_PRI_CMD, 32'h31);
    run_acc(0, 1'b0, 1'b0, 1'b0, 2, 3, 1);
    wr(`ICTC_IDX_PRI_D0, 32'h25);
    run_acc(0, 1'b1, 1'b0, 1'b0, 2, 2, 5);
    run_acc(0, 1'b1, 1'b1, 1'b0, 2, 8, 16);
    run_acc(1, 1'b0, 1'b0, 1'b1, 8, 8, 16);
    run_acc(1, 1'b0, 1'b0, 1'b0, 8, 1, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_defaults();
    t_fifo();
    t_udma();
    t_misc();
    t_shadow();
    t_strobe();
    final_report();
  end

  // Run needs under 3000 cycles
  initial begin
    #2000000;
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
